// ### design/rasx_map.svh
// Opcodes, register offsets, reset values and field positions of the ALU slice.
`ifndef RASX_MAP_SVH
`define RASX_MAP_SVH

`define RASX_OP_SUB_IMM 6'h06
`define RASX_OP_SUB_IMM_T 6'h07
`define RASX_OP_XOR 6'h0B
`define RASX_OP_MOD_SUB_IMM 6'h20
`define RASX_OP_UNPACK 6'h3F

`define RASX_OFF_MOD_MASK 12'h000
`define RASX_OFF_FLAGS 12'h004
`define RASX_OFF_STATUS 12'h008
`define RASX_OFF_LAST 12'h00C

`define RASX_MOD_MASK_RST 32'h0000_0000
`define RASX_FLAG_Z 0
`define RASX_FLAG_C 1
`define RASX_FLAG_N 2

`define RASX_UNPACK_SEL 5'h01
`define RASX_WB_CYCLE 2'h3

`endif

// ### design/rasx_pkg.sv
// Types shared by the ALU slice.
package rasx_pkg;
    typedef enum logic [3:0] {
        RASX_IDLE = 4'h1,
        RASX_READ = 4'h2,
        RASX_EXEC = 4'h4,
        RASX_WRITE = 4'h8
    } rasx_state_e;

    typedef enum logic [2:0] {
        RASX_FN_SUB = 3'h0,
        RASX_FN_SUBT = 3'h1,
        RASX_FN_MODSUB = 3'h2,
        RASX_FN_UNPACK = 3'h3,
        RASX_FN_XOR = 3'h4,
        RASX_FN_NONE = 3'h7
    } rasx_fn_e;
endpackage

// ### design/rasx_alu_core.sv
// Combinational result and flag logic of the ALU slice.
`timescale 1ns/1ps
`include "rasx_map.svh"
module rasx_alu_core
    import rasx_pkg::*;
(
    input wire rasx_fn_e fn,
    input wire logic [31:0] dst,
    input wire logic [31:0] src,
    input wire logic [4:0] imm_field,
    input wire logic [31:0] mod_mask,
    input wire logic [2:0] flags_in,
    output logic [31:0] result,
    output logic [2:0] flags_out,
    output logic writes
);
    logic [32:0] diff;
    logic [31:0] imm;
    logic [31:0] modded;
    logic [31:0] unpacked;

    // (RULE_11) Zero field means 32.
    // Field value 0 encodes 32, so the range is 1 to 32.
    assign imm = (imm_field == 5'h00) ? 32'h0000_0020
                                      : {27'h0, imm_field};
    assign diff = {1'b0, dst} - {1'b0, imm};

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_mod
            assign modded[i] = mod_mask[i] ? dst[i] : diff[i];
        end
    endgenerate

    assign unpacked = {6'h00, dst[15:12], 5'h00, dst[11:8], 5'h00, dst[7:0]};

    always_comb begin
        result = dst;
        flags_out = flags_in;
        writes = 1'b1;
        case (fn)
            RASX_FN_SUB: begin
                result = diff[31:0];
                flags_out[`RASX_FLAG_Z] = (diff[31:0] == 32'h0000_0000);
                flags_out[`RASX_FLAG_N] = diff[31];
                flags_out[`RASX_FLAG_C] = diff[32];
            end
            // (RULE_05) Flags held unchanged.
            RASX_FN_SUBT: begin
                result = diff[31:0];
            end
            // (RULE_01) Masked bits keep destination.
            RASX_FN_MODSUB: begin
                result = modded;
                flags_out[`RASX_FLAG_Z] = (modded == 32'h0000_0000);
                flags_out[`RASX_FLAG_N] = modded[31];
                // (RULE_02) Borrow taken before masking.
                flags_out[`RASX_FLAG_C] = diff[32];
            end
            // (RULE_06) Pixel field spreading.
            RASX_FN_UNPACK: begin
                result = unpacked;
                // (RULE_08) Zero set, others cleared.
                flags_out[`RASX_FLAG_Z] = (unpacked == 32'h0000_0000);
                flags_out[`RASX_FLAG_N] = 1'b0;
                flags_out[`RASX_FLAG_C] = 1'b0;
            end
            // (RULE_10) Exclusive OR flags.
            RASX_FN_XOR: begin
                result = dst ^ src;
                flags_out[`RASX_FLAG_Z] = ((dst ^ src) == 32'h0000_0000);
                flags_out[`RASX_FLAG_N] = dst[31] ^ src[31];
                flags_out[`RASX_FLAG_C] = dst[31] & src[31];
            end
            default: begin
                writes = 1'b0;
            end
        endcase
    end
endmodule

// ### design/rasx_alu.sv
// Pipelined ALU slice: immediate subtracts, pixel unpack and exclusive OR.
//
// Summary of operation
// (RULE_01) Masked subtract keeps destination where mask set.
// (RULE_02) Masked subtract flags; carry is raw borrow.
// (RULE_03) Software sets high mask bits for wrap.
// (RULE_04) Immediate subtracts read cycle 1, write 3.
// (RULE_05) Transparent subtract leaves all flags alone.
// (RULE_06) Unpack spreads pixel fields to 32 bits.
// (RULE_07) Software puts one in first register field.
// (RULE_08) Unpack sets zero, clears negative, carry.
// (RULE_09) XOR reads cycle 1, writes cycle 3.
// (RULE_10) XOR flags; carry is both sign bits.
// (RULE_11) Immediate field covers 1 to 32.
// (RULE_12) Modulo mask is software-writable 32-bit register.
`timescale 1ns/1ps
`include "rasx_map.svh"
module rasx_alu
    import rasx_pkg::*;
#(
    parameter bit IS_AUDIO = 1'b1,
    parameter bit IS_GRAPHICS = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic issue_valid,
    input wire logic [5:0] issue_opcode,
    input wire logic [4:0] first_register_field,
    input wire logic [4:0] second_register_field,
    output logic issue_ready,
    output logic [4:0] rf_rd_addr_a,
    output logic [4:0] rf_rd_addr_b,
    output logic rf_rd_en,
    input wire logic [31:0] rf_rd_data_a,
    input wire logic [31:0] rf_rd_data_b,
    output logic rf_wr_en,
    output logic [4:0] rf_wr_addr,
    output logic [31:0] rf_wr_data,
    output logic [2:0] flags
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic rasx_fn_e decode_op(input logic [5:0] op,
                                           input logic [4:0] f1);
        rasx_fn_e f;
        f = RASX_FN_NONE;
        if (op == `RASX_OP_SUB_IMM) begin
            f = RASX_FN_SUB;
        end else if (op == `RASX_OP_SUB_IMM_T) begin
            f = RASX_FN_SUBT;
        end else if (op == `RASX_OP_XOR) begin
            f = RASX_FN_XOR;
        end else if (op == `RASX_OP_MOD_SUB_IMM && IS_AUDIO) begin
            f = RASX_FN_MODSUB;
        end else if (op == `RASX_OP_UNPACK && IS_GRAPHICS
                     && f1 == `RASX_UNPACK_SEL) begin
            // Pack shares the opcode; other field values are not ours.
            f = RASX_FN_UNPACK;
        end
        return f;
    endfunction

    // ------------------------------------------------------------
    // Pipeline state
    // ------------------------------------------------------------
    rasx_state_e state_r, state_nxt;
    rasx_fn_e fn_r, fn_nxt;
    logic [4:0] f1_r, f1_nxt;
    logic [4:0] f2_r, f2_nxt;
    logic [31:0] dst_r, dst_nxt;
    logic [31:0] src_r, src_nxt;
    logic [31:0] res_r, res_nxt;
    logic wr_r, wr_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic [31:0] mod_mask_r, mod_mask_nxt;
    logic [31:0] last_r, last_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [31:0] core_res;
    logic [2:0] core_flags;
    logic core_wr;
    logic apb_wr, apb_rd;

    rasx_alu_core u_core (
        .fn(fn_r),
        .dst(dst_r),
        .src(src_r),
        .imm_field(f1_r),
        .mod_mask(mod_mask_r),
        .flags_in(flags_r),
        .result(core_res),
        .flags_out(core_flags),
        .writes(core_wr)
    );

    assign issue_ready = (state_r == RASX_IDLE);
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & ~penable & ~pwrite;

    always_comb begin
        state_nxt = state_r;
        fn_nxt = fn_r;
        f1_nxt = f1_r;
        f2_nxt = f2_r;
        dst_nxt = dst_r;
        src_nxt = src_r;
        res_nxt = res_r;
        wr_nxt = 1'b0;
        flags_nxt = flags_r;
        last_nxt = last_r;
        rf_rd_en = 1'b0;
        rf_rd_addr_a = f2_r;
        rf_rd_addr_b = f1_r;
        case (state_r)
            RASX_IDLE: begin
                if (issue_valid) begin
                    fn_nxt = decode_op(issue_opcode, first_register_field);
                    f1_nxt = first_register_field;
                    f2_nxt = second_register_field;
                    state_nxt = RASX_READ;
                end
            end
            // (RULE_04) Cycle 1 register read.
            RASX_READ: begin
                rf_rd_en = 1'b1;
                dst_nxt = rf_rd_data_a;
                // (RULE_09) Source read alongside destination.
                src_nxt = rf_rd_data_b;
                state_nxt = RASX_EXEC;
            end
            RASX_EXEC: begin
                res_nxt = core_res;
                wr_nxt = core_wr;
                flags_nxt = core_flags;
                state_nxt = RASX_WRITE;
            end
            // (RULE_04) Cycle 3 write-back.
            RASX_WRITE: begin
                if (wr_r) begin
                    last_nxt = res_r;
                end
                state_nxt = RASX_IDLE;
            end
            default: begin
                state_nxt = RASX_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    always_comb begin
        mod_mask_nxt = mod_mask_r;
        prdata_nxt = prdata_r;
        // (RULE_12) Mask written by software.
        if (apb_wr && paddr == `RASX_OFF_MOD_MASK) begin
            mod_mask_nxt = pwdata;
        end
        if (apb_rd) begin
            if (paddr == `RASX_OFF_MOD_MASK) begin
                prdata_nxt = mod_mask_r;
            end else if (paddr == `RASX_OFF_FLAGS) begin
                prdata_nxt = {29'h0, flags_r};
            end else if (paddr == `RASX_OFF_STATUS) begin
                prdata_nxt = {28'h0000000, state_r};
            end else if (paddr == `RASX_OFF_LAST) begin
                prdata_nxt = last_r;
            end else begin
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable &
                     (paddr != `RASX_OFF_MOD_MASK) &
                     (paddr != `RASX_OFF_FLAGS) &
                     (paddr != `RASX_OFF_STATUS) &
                     (paddr != `RASX_OFF_LAST);
    assign prdata = prdata_r;
    assign rf_wr_en = wr_r & (state_r == RASX_WRITE);
    assign rf_wr_addr = f2_r;
    assign rf_wr_data = res_r;
    assign flags = flags_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= RASX_IDLE;
            fn_r <= RASX_FN_NONE;
            f1_r <= 5'h00;
            f2_r <= 5'h00;
            dst_r <= 32'h0000_0000;
            src_r <= 32'h0000_0000;
            res_r <= 32'h0000_0000;
            wr_r <= 1'b0;
            flags_r <= 3'h0;
            mod_mask_r <= `RASX_MOD_MASK_RST;
            last_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            fn_r <= fn_nxt;
            f1_r <= f1_nxt;
            f2_r <= f2_nxt;
            dst_r <= dst_nxt;
            src_r <= src_nxt;
            res_r <= res_nxt;
            wr_r <= wr_nxt;
            flags_r <= flags_nxt;
            mod_mask_r <= mod_mask_nxt;
            last_r <= last_nxt;
            prdata_r <= prdata_nxt;
        end
    end
endmodule

// ### bench/rasx_alu_asserts.sv
// Checker of pipeline timing, results and flags of the ALU slice.
`timescale 1ns/1ps
`include "rasx_map.svh"
module rasx_alu_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic issue_valid,
    input wire logic [5:0] issue_opcode,
    input wire logic [4:0] first_register_field,
    input wire logic issue_ready,
    input wire logic [4:0] rf_rd_addr_a,
    input wire logic rf_rd_en,
    input wire logic [31:0] rf_rd_data_a,
    input wire logic [31:0] rf_rd_data_b,
    input wire logic rf_wr_en,
    input wire logic [4:0] rf_wr_addr,
    input wire logic [31:0] rf_wr_data,
    input wire logic [2:0] flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_read_after_take: assert property (
        issue_valid && issue_ready |=> rf_rd_en && !issue_ready)
        else $error("no read cycle after take");
    a_write_third: assert property (
        rf_wr_en |-> $past(rf_rd_en, 2))
        else $error("write not two cycles after read");
    a_write_dest: assert property (
        rf_wr_en |-> rf_wr_addr == $past(rf_rd_addr_a, 2))
        else $error("write to wrong register");
    a_write_single: assert property (
        rf_wr_en |=> !rf_wr_en)
        else $error("write pulse too long");
    a_xor_data: assert property (
        rf_rd_en && $past(issue_opcode) == `RASX_OP_XOR ##2 rf_wr_en
        |-> rf_wr_data == ($past(rf_rd_data_a, 2) ^ $past(rf_rd_data_b, 2)))
        else $error("xor result wrong");
    a_xor_flags: assert property (
        rf_rd_en && $past(issue_opcode) == `RASX_OP_XOR ##2 rf_wr_en
        |-> flags == {rf_wr_data[31], $past(rf_rd_data_a[31], 2)
        & $past(rf_rd_data_b[31], 2), rf_wr_data == 32'h0})
        else $error("xor flags wrong");
    a_flags_kept: assert property (
        issue_valid && issue_ready && issue_opcode == `RASX_OP_SUB_IMM_T
        |=> $stable(flags) [*3])
        else $error("transparent subtract moved flags");
    a_unpack_clear: assert property (
        issue_valid && issue_ready && issue_opcode == `RASX_OP_UNPACK
        && first_register_field == 5'h01 |-> ##3 flags[2:1] == 2'h0)
        else $error("unpack left n or c set");
endmodule
bind rasx_alu rasx_alu_asserts u_rasx_alu_asserts (.pclk, .presetn,
    .issue_valid, .issue_opcode, .first_register_field, .issue_ready,
    .rf_rd_addr_a, .rf_rd_en, .rf_rd_data_a, .rf_rd_data_b, .rf_wr_en,
    .rf_wr_addr, .rf_wr_data, .flags);

// ### bench/rasx_alu_tb.sv
// Self-checking bench of the ALU slice.
`timescale 1ns/1ps
`include "rasx_map.svh"
module rasx_alu_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rf_rd_data_a, rf_rd_data_b, rf_wr_data;
    logic issue_valid, issue_ready, rf_rd_en, rf_wr_en;
    logic [5:0] issue_opcode;
    logic [4:0] first_register_field, second_register_field;
    logic [4:0] rf_rd_addr_a, rf_rd_addr_b, rf_wr_addr;
    logic [2:0] flags;
    logic [31:0] rf [32];
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    // The register file answers in the same cycle, as an async read.
    assign rf_rd_data_a = rf[rf_rd_addr_a];
    assign rf_rd_data_b = rf[rf_rd_addr_b];
    rasx_alu u_rasx_alu (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_opcode,
        .first_register_field, .second_register_field, .issue_ready,
        .rf_rd_addr_a, .rf_rd_addr_b, .rf_rd_en, .rf_rd_data_a,
        .rf_rd_data_b, .rf_wr_en, .rf_wr_addr, .rf_wr_data, .flags);
    always #50 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            stop_test;
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Destination is always register 3; f1 is immediate or source.
    task op(input logic [5:0] oc, input logic [4:0] f1,
            input logic [31:0] d, s, input logic wr,
            input logic [31:0] res, input logic [2:0] fl);
        rf[3] <= d;
        if (f1 != 5'h03) begin
            rf[f1] <= s;
        end
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_opcode <= oc;
        first_register_field <= f1;
        second_register_field <= 5'h03;
        @(posedge pclk);
        issue_valid <= 1'b0;
        #1 chk("rd_en", {31'h0, rf_rd_en}, 32'h1);
        repeat (2) @(posedge pclk);
        #1 chk("wr_en", {31'h0, rf_wr_en}, {31'h0, wr});
        if (wr) begin
            chk("wr_addr", {27'h0, rf_wr_addr}, 32'h3);
            chk("wr_data", rf_wr_data, res);
        end
        chk("flags", {29'h0, flags}, {29'h0, fl});
        @(posedge pclk);
    endtask
    task t_regs;
        logic [31:0] rd;
        logic err;
        apb(1'b0, `RASX_OFF_MOD_MASK, 32'h0, rd, err);
        chk("mask_rst", rd, `RASX_MOD_MASK_RST);
        apb(1'b1, `RASX_OFF_MOD_MASK, 32'hFFFF_FFF0, rd, err);
        apb(1'b0, `RASX_OFF_MOD_MASK, 32'h0, rd, err);
        chk("mask_rd", rd, 32'hFFFF_FFF0);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk("unmapped", {rd[30:0], err}, 32'h1);
    endtask
    task t_sub;
        op(`RASX_OP_SUB_IMM, 5'h00, 32'h20, 32'h0, 1'b1, 32'h0,
           3'h1);
        op(`RASX_OP_SUB_IMM, 5'h06, 32'h5, 32'h0, 1'b1, 32'hFFFF_FFFF,
           3'h6);
        op(`RASX_OP_SUB_IMM_T, 5'h01, 32'h1, 32'h0, 1'b1, 32'h0,
           3'h6);
    endtask
    task t_mod;
        op(`RASX_OP_MOD_SUB_IMM, 5'h05, 32'h103, 32'h0, 1'b1, 32'h10E,
           3'h0);
        op(`RASX_OP_MOD_SUB_IMM, 5'h03, 32'h2, 32'h0, 1'b1, 32'hF,
           3'h2);
    endtask
    task t_unpack;
        op(`RASX_OP_UNPACK, 5'h01, 32'hFFFF_ABCD, 32'h0, 1'b1, 32'h0281_60CD,
           3'h0);
        op(`RASX_OP_UNPACK, 5'h01, 32'hFFFF_0000, 32'h0, 1'b1, 32'h0,
           3'h1);
        op(`RASX_OP_UNPACK, 5'h02, 32'h1234, 32'h0, 1'b0, 32'h0,
           3'h1);
    endtask
    task t_xor;
        op(`RASX_OP_XOR, 5'h04, 32'h8000_0001, 32'h8000_0001, 1'b1, 32'h0,
           3'h3);
        op(`RASX_OP_XOR, 5'h04, 32'h8000_0000, 32'h1, 1'b1, 32'h8000_0001,
           3'h4);
    endtask
    // Flags, last result and state as software sees them after the XOR.
    task t_readback;
        logic [31:0] rd;
        logic err;
        apb(1'b0, `RASX_OFF_FLAGS, 32'h0, rd, err);
        chk("flags_reg", rd, 32'h4);
        apb(1'b0, `RASX_OFF_LAST, 32'h0, rd, err);
        chk("last_reg", rd, 32'h8000_0001);
        apb(1'b0, `RASX_OFF_STATUS, 32'h0, rd, err);
        chk("status_reg", {rd[30:0], err}, 32'h2);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        issue_valid = 1'b0;
        issue_opcode = 6'h00;
        first_register_field = 5'h00;
        second_register_field = 5'h00;
        foreach (rf[i]) rf[i] = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_sub;
        t_mod;
        t_unpack;
        t_xor;
        t_readback;
        stop_test;
    end
endmodule
